// [rtl/rgc_top.sv]
// Regulator, vibrator, core discharge and pin control register slice
// Notes on behaviour
// - Vibrator bit set turns vibrator transistor on
// - Core discharge in wait, or low power when off
// - Second regulator enable and sleep-off decode
// - First regulator uses same enable/sleep-off decode
// - Voltage code accepted while disabled or enabling
// - Second regulator codes 1.8/2.5/3.0/3.3 V
// - First regulator codes adj/2.5/2.75/3.0 V
// - Regulator register resets with both enables set
// - Input pins interrupt on chosen edge polarity
// - Mask bit suppresses pin interrupt, resets unmasked
// - Direction bit: 0 input, 1 output, reset input
// - Output value 1 pulls the pin low
// - Input pin value bit reads pin level
// - Writes to value bits of inputs ignored
// - Sleep pin with enable picks low power or wait
// - Core-off bit disables core converter in low power
`timescale 1ns/1ps
`default_nettype none
module rgc_top
  import rgc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic SLEEP_REQ,
  output logic LOW_POWER_MODE,
  output logic WAIT_MODE,
  output logic VIB_DRIVE_ON,
  output logic CORE_CONV_ON,
  output logic CORE_DISCHARGE_ON,
  output logic REG1_ON,
  output logic REG1_REDUCED,
  output logic REG1_ADJ,
  output logic [11:0] REG1_MV,
  output logic REG2_ON,
  output logic REG2_REDUCED,
  output logic REG2_ADJ,
  output logic [11:0] REG2_MV,
  input wire logic [3:0] GPIO_IN,
  output logic [3:0] GPIO_OUT,
  output logic [3:0] GPIO_OE,
  output logic PIN_IRQ
);
  logic [7:0] supply_q;
  logic [7:0] core_q;
  logic [7:0] regs_q;
  logic [7:0] mask_q;
  rgc_pins_t dir_q;
  rgc_pins_t val_q;
  rgc_pins_t pend_q;
  rgc_pins_t pin_lvl;
  rgc_pins_t pin_evt;
  rgc_pins_t pend_set;
  rgc_pins_t gpio_rd;
  logic sleep_s1_q;
  logic sleep_s2_q;
  logic lp_d;
  logic wait_d;
  logic core_off_d;
  logic [7:0] rdata_d;
  logic wr_supply;
  logic wr_core;
  logic wr_regs;
  logic wr_mask;
  logic wr_gpio;
  logic wr_pend;
  logic seen_regs_wr_q;

  // Write strobes per register
  assign wr_supply = REG_WR & (REG_ADDR == ADDR_SUPPLY);
  assign wr_core = REG_WR & (REG_ADDR == ADDR_CORE);
  assign wr_regs = REG_WR & (REG_ADDR == ADDR_REGS);
  assign wr_mask = REG_WR & (REG_ADDR == ADDR_MASK);
  assign wr_gpio = REG_WR & (REG_ADDR == ADDR_GPIO);
  assign wr_pend = REG_WR & (REG_ADDR == ADDR_PEND);

  // Supply-mode select and low-power enable bits
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      supply_q <= SUPPLY_RST;
    end else if (wr_supply) begin
      supply_q <= REG_WDATA & SUPPLY_WMASK;
    end
  end

  // Core converter control bits: core-off, vibrator, discharge
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      core_q <= CORE_RST;
    end else if (wr_core) begin
      core_q <= REG_WDATA & CORE_WMASK;
    end
  end

  // Regulator register; any enable and code mix is taken whole
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      regs_q <= REGS_RST;
    end else if (wr_regs) begin
      regs_q <= REG_WDATA;
    end
  end

  // Edge polarity and mask register
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_q <= MASK_RST;
    end else if (wr_mask) begin
      mask_q <= REG_WDATA;
    end
  end

  // Pin direction; all pins start as inputs
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dir_q <= NIB_RST;
    end else if (wr_gpio) begin
      dir_q <= REG_WDATA[7:POS_HI];
    end
  end

  // Value bits change only for pins that are outputs now
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      val_q <= NIB_RST;
    end else if (wr_gpio) begin
      val_q <= (REG_WDATA[3:0] & dir_q) | (val_q & ~dir_q);
    end
  end

  // Sleep request pin synchroniser
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end else begin
      sleep_s1_q <= SLEEP_REQ;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  // Mode decode from the sleep pin and the supply bits
  assign lp_d = sleep_s2_q & supply_q[BIT_LPEN] & supply_q[BIT_SUPSEL];
  assign wait_d = sleep_s2_q & supply_q[BIT_LPEN] & ~supply_q[BIT_SUPSEL];
  assign core_off_d = wait_d | (lp_d & core_q[BIT_COREOFF]);

  // Mode, vibrator and core converter outputs
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      LOW_POWER_MODE <= 1'b0;
      WAIT_MODE <= 1'b0;
      VIB_DRIVE_ON <= 1'b0;
      CORE_CONV_ON <= 1'b1;
      CORE_DISCHARGE_ON <= 1'b0;
    end else begin
      LOW_POWER_MODE <= lp_d;
      WAIT_MODE <= wait_d;
      VIB_DRIVE_ON <= core_q[BIT_VIB];
      CORE_CONV_ON <= ~core_off_d;
      CORE_DISCHARGE_ON <= core_q[BIT_CDIS] & core_off_d;
    end
  end

  // First regulator
  rgc_ldo_ctrl #(.FIRST(1'b1)) u_ldo1 (
    .clk(CLK),
    .rst_b(RST_B),
    .en(regs_q[BIT_R1EN]),
    .sleep_off(regs_q[BIT_R1OFF]),
    .vcode(regs_q[POS_R1V+1:POS_R1V]),
    .low_power(lp_d),
    .on_q(REG1_ON),
    .reduced_q(REG1_REDUCED),
    .adj_q(REG1_ADJ),
    .mv_q(REG1_MV)
  );

  // Second regulator
  rgc_ldo_ctrl #(.FIRST(1'b0)) u_ldo2 (
    .clk(CLK),
    .rst_b(RST_B),
    .en(regs_q[BIT_R2EN]),
    .sleep_off(regs_q[BIT_R2OFF]),
    .vcode(regs_q[POS_R2V+1:POS_R2V]),
    .low_power(lp_d),
    .on_q(REG2_ON),
    .reduced_q(REG2_REDUCED),
    .adj_q(REG2_ADJ),
    .mv_q(REG2_MV)
  );

  // One synchroniser and edge detector per pin
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    rgc_pin_sense u_sense (
      .clk(CLK),
      .rst_b(RST_B),
      .pin(GPIO_IN[i]),
      .rise_sel(mask_q[POS_HI+i]),
      .level(pin_lvl[i]),
      .edge_evt(pin_evt[i])
    );
  end

  // Unmasked edges on input pins raise a pending flag
  assign pend_set = pin_evt & ~dir_q & ~mask_q[3:0];

  // Sticky flags, cleared by writing ones; a new edge wins
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_q <= NIB_RST;
    end else begin
      pend_q <= (pend_q & ~(wr_pend ? REG_WDATA[3:0] : NIB_RST))
                | pend_set;
    end
  end

  // Open-drain pins: drive low when output and value is 1
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      GPIO_OE <= NIB_RST;
      GPIO_OUT <= NIB_RST;
      PIN_IRQ <= 1'b0;
    end else begin
      GPIO_OE <= dir_q & val_q;
      GPIO_OUT <= NIB_RST;
      PIN_IRQ <= |pend_q;
    end
  end

  // Input pins read their level, outputs their stored value
  assign gpio_rd = (val_q & dir_q) | (pin_lvl & ~dir_q);

  // Read data mux, unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    case (REG_ADDR)
      ADDR_SUPPLY: rdata_d = supply_q;
      ADDR_CORE: rdata_d = core_q;
      ADDR_REGS: rdata_d = regs_q;
      ADDR_MASK: rdata_d = mask_q;
      ADDR_GPIO: rdata_d = {dir_q, gpio_rd};
      ADDR_PEND: rdata_d = {4'h0, pend_q};
      default: rdata_d = 8'h00;
    endcase
  end

  // Registered read data
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_d;
    end
  end

  // Helper: regulator register not yet written since reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      seen_regs_wr_q <= 1'b0;
    end else if (wr_regs) begin
      seen_regs_wr_q <= 1'b1;
    end
  end

  // Checks
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_vib_on;
    wr_core && REG_WDATA[BIT_VIB] |=> ##1 VIB_DRIVE_ON;
  endproperty
  a_vib_on: assert property (p_vib_on)
    else $error("vibrator not on after write");

  property p_discharge;
    CORE_DISCHARGE_ON |-> (WAIT_MODE || LOW_POWER_MODE) && !CORE_CONV_ON;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("core discharge outside converter off");

  property p_reg2_sleep_off;
    LOW_POWER_MODE && $past(regs_q[BIT_R2OFF]) |-> !REG2_ON;
  endproperty
  a_reg2_sleep_off: assert property (p_reg2_sleep_off)
    else $error("second regulator on in low power with sleep-off");

  property p_reg1_reduced;
    LOW_POWER_MODE && $past(regs_q[BIT_R1EN] && !regs_q[BIT_R1OFF])
      |-> REG1_ON && REG1_REDUCED;
  endproperty
  a_reg1_reduced: assert property (p_reg1_reduced)
    else $error("first regulator not reduced in low power");

  property p_reg2_mv;
    wr_regs && REG_WDATA[5:4] == 2'h3 |=> ##1 REG2_MV == MV_3300;
  endproperty
  a_reg2_mv: assert property (p_reg2_mv)
    else $error("second regulator code 3 not 3.3 V");

  property p_reg1_mv;
    wr_regs && REG_WDATA[1:0] == 2'h2 |=> ##1 REG1_MV == MV_2750 && !REG1_ADJ;
  endproperty
  a_reg1_mv: assert property (p_reg1_mv)
    else $error("first regulator code 2 not 2.75 V");

  property p_regs_reset;
    !seen_regs_wr_q |-> regs_q == REGS_RST;
  endproperty
  a_regs_reset: assert property (p_regs_reset)
    else $error("regulator register lost its reset value");

  property p_edge_pend;
    pin_evt[0] && !dir_q[0] && !mask_q[0] |=> pend_q[0] ##1 PIN_IRQ;
  endproperty
  a_edge_pend: assert property (p_edge_pend)
    else $error("pin edge did not raise interrupt");

  property p_mask_hold;
    mask_q[2] && !pend_q[2] |=> !pend_q[2];
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("masked pin set its flag");

  property p_od_drive;
    dir_q[0] && val_q[0] |=> GPIO_OE[0];
  endproperty
  a_od_drive: assert property (p_od_drive)
    else $error("output pin not pulled low");

  property p_in_read;
    REG_ADDR == ADDR_GPIO && !dir_q[2] |=> REG_RDATA[2] == $past(pin_lvl[2]);
  endproperty
  a_in_read: assert property (p_in_read)
    else $error("input pin value not read back");

  property p_in_nowrite;
    wr_gpio && !dir_q[3] |=> $stable(val_q[3]);
  endproperty
  a_in_nowrite: assert property (p_in_nowrite)
    else $error("write changed an input pin value bit");

  property p_low_power;
    (sleep_s2_q && supply_q[BIT_LPEN] && supply_q[BIT_SUPSEL]) [*2]
      |=> LOW_POWER_MODE && !WAIT_MODE;
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power mode not entered");

  property p_core_off;
    LOW_POWER_MODE && $past(core_q[BIT_COREOFF]) |-> !CORE_CONV_ON;
  endproperty
  a_core_off: assert property (p_core_off)
    else $error("core converter on in low power with core-off");

  property p_set_wins;
    pend_set[1] && wr_pend && REG_WDATA[1] |=> pend_q[1];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("edge lost under clear");

  c_low_power: cover property (LOW_POWER_MODE && REG1_REDUCED);
  c_wait: cover property (WAIT_MODE && CORE_DISCHARGE_ON);
  c_irq: cover property ($rose(PIN_IRQ));
  c_od_low: cover property (GPIO_OE != NIB_RST);
endmodule : rgc_top
`default_nettype wire

// [rtl/rgc_pkg.sv]
// Shared constants for the regulator and pin control register slice
package rgc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_SUPPLY = 8'h0c;
  localparam logic [7:0] ADDR_CORE = 8'h0d;
  localparam logic [7:0] ADDR_REGS = 8'h0e;
  localparam logic [7:0] ADDR_MASK = 8'h0f;
  localparam logic [7:0] ADDR_GPIO = 8'h10;
  localparam logic [7:0] ADDR_PEND = 8'h11;
  // Values after reset
  localparam logic [7:0] SUPPLY_RST = 8'h10;
  localparam logic [7:0] CORE_RST = 8'h00;
  localparam logic [7:0] REGS_RST = 8'h88;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic LDO_ON_RST = 1'b1;
  // Bits held in the partly implemented registers
  localparam logic [7:0] SUPPLY_WMASK = 8'h18;
  localparam logic [7:0] CORE_WMASK = 8'h83;
  // Field positions
  localparam int BIT_SUPSEL = 4;
  localparam int BIT_LPEN = 3;
  localparam int BIT_COREOFF = 7;
  localparam int BIT_VIB = 1;
  localparam int BIT_CDIS = 0;
  localparam int BIT_R2EN = 7;
  localparam int BIT_R2OFF = 6;
  localparam int POS_R2V = 4;
  localparam int BIT_R1EN = 3;
  localparam int BIT_R1OFF = 2;
  localparam int POS_R1V = 0;
  localparam int POS_HI = 4;
  localparam int NPINS = 4;
  // Output voltages in millivolts
  localparam logic [11:0] MV_ADJ = 12'h000;
  localparam logic [11:0] MV_1800 = 12'd1800;
  localparam logic [11:0] MV_2500 = 12'd2500;
  localparam logic [11:0] MV_2750 = 12'd2750;
  localparam logic [11:0] MV_3000 = 12'd3000;
  localparam logic [11:0] MV_3300 = 12'd3300;

  typedef logic [NPINS-1:0] rgc_pins_t;

  // Voltage code decode for either regulator
  function automatic logic [11:0] rgc_mv(input logic first,
                                         input logic [1:0] code);
    logic [11:0] mv;
    mv = MV_ADJ;
    case (code)
      2'h0: mv = first ? MV_ADJ : MV_1800;
      2'h1: mv = MV_2500;
      2'h2: mv = first ? MV_2750 : MV_3000;
      default: mv = first ? MV_3000 : MV_3300;
    endcase
    return mv;
  endfunction : rgc_mv
endpackage : rgc_pkg

// [rtl/rgc_pin_sense.sv]
// Pin input synchroniser and polarity-selected edge detector
`timescale 1ns/1ps
`default_nettype none
module rgc_pin_sense
  import rgc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  input wire logic rise_sel,
  output logic level,
  output logic edge_evt
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Two stages into the clock domain, a third for edge history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Start at the pulled-up idle level so no false edge follows reset
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Rising edge when selected, falling edge otherwise
  assign level = s2_q;
  assign edge_evt = rise_sel ? (s2_q & ~s3_q) : (~s2_q & s3_q);
endmodule : rgc_pin_sense
`default_nettype wire

// [rtl/rgc_ldo_ctrl.sv]
// Enable, low-power and voltage decode for one linear regulator
`timescale 1ns/1ps
`default_nettype none
module rgc_ldo_ctrl
  import rgc_pkg::*;
#(
  parameter bit FIRST = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic en,
  input wire logic sleep_off,
  input wire logic [1:0] vcode,
  input wire logic low_power,
  output logic on_q,
  output logic reduced_q,
  output logic adj_q,
  output logic [11:0] mv_q
);
  localparam logic [11:0] MV_RST = rgc_mv(FIRST, 2'h0);

  // Off when disabled; in low power either reduced or off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      on_q <= LDO_ON_RST;
      reduced_q <= 1'b0;
    end else begin
      on_q <= en & ~(low_power & sleep_off);
      reduced_q <= en & low_power & ~sleep_off;
    end
  end

  // Voltage code decode, the adjustable level flagged apart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mv_q <= MV_RST;
      adj_q <= FIRST;
    end else begin
      mv_q <= rgc_mv(FIRST, vcode);
      adj_q <= FIRST & (vcode == 2'h0);
    end
  end
endmodule : rgc_ldo_ctrl
`default_nettype wire

// [dv/rgc_pin_load.sv]
// Pin loads: pull-ups plus an outside driver that can sink each pin
`timescale 1ns/1ps
`default_nettype none
module rgc_pin_load
  import rgc_pkg::*;
(
  input wire logic [NPINS-1:0] oe,
  input wire logic [NPINS-1:0] ext_low,
  output logic [NPINS-1:0] level
);
  // Pull-up wins unless the device or the outside world sinks the pin
  assign level = ~(oe | ext_low);
endmodule : rgc_pin_load
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the regulator and pin control register slice
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rgc_pkg::*;
  typedef struct packed {
    logic [2:0] kind;
    logic [31:0] val;
  } rgc_note_t;
  localparam logic [2:0] K_RD = 3'h0;
  localparam logic [2:0] K_PWR = 3'h1;
  localparam logic [2:0] K_LDO = 3'h2;
  localparam logic [2:0] K_MV = 3'h3;
  localparam logic [2:0] K_PIN = 3'h4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic sleep_req = 1'b0;
  logic [3:0] ext_low = 4'h0;
  logic [7:0] rdata;
  logic lpm, wtm, vibrator_drive_enable, conv, dis, r1on, r1red, r1adj, r2on, r2red, r2adj;
  logic [11:0] r1mv, r2mv;
  logic [3:0] gin, gout, oe;
  logic irq;
  int n_mismatch = 0;
  int tests_run = 0;
  rgc_note_t notes[$];
  event look;
  logic [11:0] mv1_tab [4] = '{MV_ADJ, MV_2500, MV_2750, MV_3000};
  logic [11:0] mv2_tab [4] = '{MV_1800, MV_2500, MV_3000, MV_3300};

  // Clock at 100 MHz
  always #5 clk = ~clk;

  rgc_top u_dut (
    .CLK(clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
    .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .SLEEP_REQ(sleep_req),
    .LOW_POWER_MODE(lpm), .WAIT_MODE(wtm), .VIB_DRIVE_ON(vibrator_drive_enable),
    .CORE_CONV_ON(conv), .CORE_DISCHARGE_ON(dis), .REG1_ON(r1on),
    .REG1_REDUCED(r1red), .REG1_ADJ(r1adj), .REG1_MV(r1mv),
    .REG2_ON(r2on), .REG2_REDUCED(r2red), .REG2_ADJ(r2adj),
    .REG2_MV(r2mv), .GPIO_IN(gin), .GPIO_OUT(gout), .GPIO_OE(oe),
    .PIN_IRQ(irq)
  );

  rgc_pin_load u_pins (.oe(oe), .ext_low(ext_low), .level(gin));

  // Output vector selected by the kind of note
  function automatic logic [31:0] obs(input logic [2:0] k);
    case (k)
      K_PWR: obs = {27'h0, vibrator_drive_enable, conv, dis, lpm, wtm};
      K_LDO: obs = {28'h0, r1on, r1red, r2on, r2red};
      K_MV: obs = {6'h0, r2adj, r1adj, r1mv, r2mv};
      default: obs = {23'h0, oe, gout, irq};
    endcase
  endfunction : obs

  // Expected on and reduced flags of one regulator
  function automatic logic [1:0] ldo(input logic e, input logic o,
                                     input logic lp);
    ldo = {e & ~(lp & o), e & lp & ~o};
  endfunction : ldo

  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] a);
    tests_run++;
    if (a !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t read exp=%h got=%h", $time, e, a);
    end
  endtask : cmp_rd

  task automatic cmp_out(input logic [31:0] e, input logic [31:0] a);
    tests_run++;
    if (a !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t output exp=%h got=%h", $time, e, a);
    end
  endtask : cmp_out

  // Result watcher: takes the oldest note when a result is due
  always @(look) begin : mon
    rgc_note_t n;
    n = notes.pop_front();
    if (n.kind === K_RD) begin
      cmp_rd(n.val[7:0], rdata);
    end else begin
      cmp_out(n.val, obs(n.kind));
    end
  end

  task automatic note(input logic [2:0] k, input logic [31:0] v);
    @(negedge clk);
    notes.push_back({k, v});
    -> look;
  endtask : note

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    note(K_RD, {24'h0, e});
  endtask : rd

  // Derived outputs settle two edges after the write edge
  task automatic ow(input logic [2:0] k, input logic [31:0] v);
    repeat (2) @(posedge clk);
    note(k, v);
  endtask : ow

  task automatic sleep(input logic v);
    @(posedge clk);
    sleep_req <= v;
    repeat (3) @(posedge clk);
  endtask : sleep

  task automatic pins(input logic [3:0] v);
    @(posedge clk);
    ext_low <= v;
    repeat (6) @(posedge clk);
  endtask : pins

  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin : main
    logic [1:0] c;
    logic [1:0] d;
    logic [31:0] r;
    r = $urandom(32'h7b15);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_REGS, 8'h88);
    rd(ADDR_MASK, 8'h00);
    rd(ADDR_GPIO, 8'h0f);
    ow(K_LDO, 32'ha);
    ow(K_MV, {6'h0, 1'b0, 1'b1, MV_ADJ, MV_1800});
    ow(K_PIN, 32'h0);
    ow(K_PWR, 32'h08);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      d = 2'($urandom);
      wr(ADDR_REGS, {2'b00, c, 2'b00, d});
      ow(K_LDO, 32'h0);
      ow(K_MV, {6'h0, 1'b0, d == 2'h0, mv1_tab[d], mv2_tab[c]});
      wr(ADDR_REGS, {2'b10, d, 2'b10, c});
      rd(ADDR_REGS, {2'b10, d, 2'b10, c});
      ow(K_MV, {6'h0, 1'b0, c == 2'h0, mv1_tab[c], mv2_tab[d]});
    end
    for (int lp = 1; lp >= 0; lp--) begin
      wr(ADDR_SUPPLY, 8'h18);
      sleep(1'(lp));
      ow(K_PWR, {27'h0, 2'b01, 1'b0, 1'(lp), 1'b0});
      for (int j = 0; j < 4; j++) begin
        c = 2'(j);
        wr(ADDR_REGS, {c[0], c[1], 2'b00, c[1], c[0], 2'b00});
        ow(K_LDO, {28'h0, ldo(c[1], c[0], 1'(lp)),
                   ldo(c[0], c[1], 1'(lp))});
      end
    end
    sleep(1'b1);
    wr(ADDR_CORE, 8'h81);
    ow(K_PWR, 32'h06);
    wr(ADDR_CORE, 8'h01);
    ow(K_PWR, 32'h0a);
    wr(ADDR_CORE, 8'h7f);
    ow(K_PWR, 32'h1a);
    rd(ADDR_CORE, 8'h03);
    wr(ADDR_SUPPLY, 8'hef);
    ow(K_PWR, 32'h15);
    rd(ADDR_SUPPLY, 8'h08);
    sleep(1'b0);
    ow(K_PWR, 32'h18);
    wr(ADDR_CORE, 8'h00);
    ow(K_PWR, 32'h08);
    // Value bits land only for pins that were outputs before the write
    wr(ADDR_GPIO, 8'hf0);
    wr(ADDR_GPIO, 8'hf5);
    ow(K_PIN, {23'h0, 4'h5, 4'h0, 1'b0});
    rd(ADDR_GPIO, 8'hf5);
    wr(ADDR_GPIO, {4'h0, r[3:0]});
    wr(ADDR_GPIO, {4'h0, ~r[3:0]});
    wr(ADDR_GPIO, 8'hf0);
    rd(ADDR_GPIO, {4'hf, r[3:0]});
    // Let pulled-down pins settle, then release them and resync
    repeat (4) @(posedge clk);
    wr(ADDR_GPIO, 8'h00);
    repeat (3) @(posedge clk);
    rd(ADDR_GPIO, 8'h0f);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    wr(ADDR_MASK, 8'h0c);
    pins(4'hf);
    rd(ADDR_GPIO, 8'h00);
    ow(K_PIN, 32'h1);
    rd(ADDR_PEND, 8'h03);
    wr(ADDR_PEND, 8'h0f);
    ow(K_PIN, 32'h0);
    wr(ADDR_MASK, 8'h50);
    pins(4'h0);
    rd(ADDR_PEND, 8'h05);
    ow(K_PIN, 32'h1);
    wr(ADDR_PEND, 8'h0f);
    ow(K_PIN, 32'h0);
    // An edge in the very cycle of a clear keeps its flag
    fork
      pins(4'h2);
      begin
        repeat (2) @(posedge clk);
        wr(ADDR_PEND, 8'h0f);
      end
    join
    ow(K_PIN, 32'h1);
    rd(ADDR_PEND, 8'h02);
    wr(ADDR_PEND, 8'h0f);
    ow(K_PIN, 32'h0);
    repeat (2) @(posedge clk);
    close_out();
  end

  // Watchdog against a hang
  initial begin : watchdog
    #100us;
    n_mismatch++;
    close_out();
  end
endmodule : tb
`default_nettype wire
